// [verilog/gpx_port.sv]
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
// Eight-pin I/O port with APB registers
module gpx_port (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire gpx_pkg::gpx_apb_req_s apbReq,
	output gpx_pkg::gpx_apb_rsp_s apbRsp,
	input wire logic [7:0] padIn,
	output gpx_pkg::gpx_pad_s pad,
	input wire gpx_pkg::gpx_alt_s alt,
	output logic [7:0] altIn,
	input wire logic vectorFetch,
	output logic irqReq
);
	import gpx_pkg::*;

	typedef struct packed {
		logic [7:0] dataLatch;
		logic [7:0] dir;
		logic [7:0] opt;
		logic [1:0] sens;
		logic sensChg;
		gpx_apb_rsp_s rsp;
		gpx_pad_s pad;
		logic [7:0] altIn;
	} gpx_port_s;

	gpx_port_s q, d;
	logic [7:0] pinLvl;
	logic irqOut;
	logic wrEn;
	logic rdEn;

	gpx_sync #(.W(GPX_WIDTH)) uSync (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.din(padIn),
		.dout(pinLvl)
	);

	// option one on input enables interrupt
	gpx_irq_group #(.W(GPX_WIDTH)) uIrq (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.pinSync(pinLvl),
		.irqEnable(~q.dir & q.opt & ~alt.en),
		.sens(q.sens),
		.sensChanged(q.sensChg),
		.vectorFetch(vectorFetch),
		.irqReq(irqOut)
	);

	// Access phase strobes
	assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite & ~q.rsp.pready;
	assign rdEn = apbReq.psel & apbReq.penable & ~apbReq.pwrite & ~q.rsp.pready;

	// Next state
	always_comb begin
		d = q;
		d.sensChg = 1'b0;
		d.rsp.pready = 1'b0;
		d.rsp.pslverr = 1'b0;
		// Register writes, one-cycle-late ready
		if (wrEn) begin
			d.rsp.pready = 1'b1;
			unique case (apbReq.paddr)
				GPX_OFS_DATA: d.dataLatch = apbReq.pwdata[7:0];
				GPX_OFS_DIR: d.dir = apbReq.pwdata[7:0];
				GPX_OFS_OPT: d.opt = apbReq.pwdata[7:0];
				GPX_OFS_SENS: begin
					d.sens = apbReq.pwdata[1:0];
					d.sensChg = (apbReq.pwdata[1:0] != q.sens);
				end
				GPX_OFS_STAT: d.rsp.pslverr = 1'b1;
				default: d.rsp.pslverr = 1'b1;
			endcase
		end
		if (rdEn) begin
			d.rsp.pready = 1'b1;
			d.rsp.prdata = '0;
			unique case (apbReq.paddr)
				GPX_OFS_DATA: d.rsp.prdata[7:0] = pinLvl;
				GPX_OFS_DIR: d.rsp.prdata[7:0] = q.dir;
				GPX_OFS_OPT: d.rsp.prdata[7:0] = q.opt;
				GPX_OFS_SENS: d.rsp.prdata[1:0] = q.sens;
				GPX_OFS_STAT: d.rsp.prdata[0] = irqOut;
				default: d.rsp.pslverr = 1'b1;
			endcase
		end
		for (int i = 0; i < GPX_WIDTH; i++) begin
			if (alt.en[i]) begin
				d.pad.out[i] = alt.out[i];
				d.pad.oeN[i] = ~(alt.pushPull[i] | ~alt.out[i]);
			// output from latch, type by option
			end else if (q.dir[i]) begin
				d.pad.out[i] = q.dataLatch[i];
				d.pad.oeN[i] = ~(q.opt[i] | ~q.dataLatch[i]);
			end else begin
				d.pad.out[i] = 1'b0;
				d.pad.oeN[i] = 1'b1;
			end
		end
		d.altIn = pinLvl;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q.dataLatch <= GPX_RST_PORT;
			q.dir <= GPX_RST_PORT;
			q.opt <= GPX_RST_PORT;
			q.sens <= GPX_RST_SENS;
			q.sensChg <= 1'b0;
			q.rsp <= '0;
			q.pad <= '{out: 8'h00, oeN: 8'hFF};
			q.altIn <= 8'h00;
		end else if (ce) begin
			q <= d;
		end
	end

	assign apbRsp = q.rsp;
	assign pad = q.pad;
	assign altIn = q.altIn;
	assign irqReq = irqOut;
endmodule : gpx_port

// [common/gpx_pkg.sv]
// Summary of operation
// - Eight pins, each input, interrupt input, output
// - Register bit X controls pin X
// - Direction zero: input, read returns pin
// - Input mode: data write updates latch only
// - Interrupt input pin raises group request
// - Sensitivity bits select edge or level
// - Enabled pins NANDed then inverted per group
// - Request latch, read in status bit 0, cleared on vector fetch
// - Changing sensitivity bits discards pending request
// - Direction one: drive from latch, option type
// - Zero pulls low; one high or floating
// - Data read returns pin level always
// - Peripheral use overrides ordinary port configuration
// - Peripheral output forces pin into output
// - Peripheral input: pin input, still readable
// - Option: interrupt/plain input; push-pull/open drain
// - Data, direction, option reset to zero
package gpx_pkg;
	localparam int GPX_WIDTH = 8;
	localparam logic [11:0] GPX_OFS_DATA = 12'h000;
	localparam logic [11:0] GPX_OFS_DIR = 12'h004;
	localparam logic [11:0] GPX_OFS_OPT = 12'h008;
	localparam logic [11:0] GPX_OFS_SENS = 12'h00C;
	localparam logic [11:0] GPX_OFS_STAT = 12'h010;
	localparam logic [7:0] GPX_RST_PORT = 8'h00;
	localparam logic [1:0] GPX_RST_SENS = 2'h0;
	// Sensitivity encodings
	localparam logic [1:0] GPX_SENS_FALL_LOW = 2'h0;
	localparam logic [1:0] GPX_SENS_RISE = 2'h1;
	localparam logic [1:0] GPX_SENS_FALL = 2'h2;
	localparam logic [1:0] GPX_SENS_BOTH = 2'h3;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oeN;
	} gpx_pad_s;

	typedef struct packed {
		logic [7:0] en;
		logic [7:0] out;
		logic [7:0] pushPull;
	} gpx_alt_s;

	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} gpx_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} gpx_apb_rsp_s;
endpackage : gpx_pkg

// [verilog/gpx_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels
module gpx_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gpx_sync_s;
	gpx_sync_s q, d;

	// Capture pins in stage one, shift stage one into stage two
	always_comb begin
		d = q;
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign dout = q.s2;
endmodule : gpx_sync

// [verilog/gpx_irq_group.sv]
`timescale 1ns/1ps
// Combined interrupt request of one pin group
module gpx_irq_group #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [W-1:0] pinSync,
	input wire logic [W-1:0] irqEnable,
	input wire logic [1:0] sens,
	input wire logic sensChanged,
	input wire logic vectorFetch,
	output logic irqReq
);
	import gpx_pkg::*;
	typedef struct packed {
		logic prev;
		logic req;
	} gpx_irqg_s;
	gpx_irqg_s q, d;
	logic comb;
	logic event_;

	// NAND then invert, low masks others
	assign comb = ~(~&(pinSync | ~irqEnable));

	always_comb begin
		unique case (sens)
			GPX_SENS_FALL_LOW: event_ = ~comb;
			GPX_SENS_RISE: event_ = comb & ~q.prev;
			GPX_SENS_FALL: event_ = ~comb & q.prev;
			GPX_SENS_BOTH: event_ = comb ^ q.prev;
		endcase
	end

	// Request latch update
	always_comb begin
		d = q;
		d.prev = comb;
		if (vectorFetch || sensChanged) begin
			d.req = 1'b0;
		end
		if (event_ && !sensChanged && |irqEnable) begin
			d.req = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{prev: 1'b1, req: 1'b0};
		end else if (ce) begin
			q <= d;
		end
	end

	assign irqReq = q.req;
endmodule : gpx_irq_group

// [tb/gpx_port_props.sv]
`timescale 1ns/1ps
// Checks at the port boundary
module gpx_port_props (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire gpx_pkg::gpx_apb_req_s apbReq,
	input wire gpx_pkg::gpx_apb_rsp_s apbRsp,
	input wire logic [7:0] padIn,
	input wire gpx_pkg::gpx_pad_s pad,
	input wire gpx_pkg::gpx_alt_s alt,
	input wire logic [7:0] altIn,
	input wire logic vectorFetch,
	input wire logic irqReq
);
	import gpx_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	chk_rdy_wait: assert property (ce && apbReq.psel && apbReq.penable && !apbRsp.pready
		|=> apbRsp.pready) else $error("late ready");
	chk_rdy_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("long ready");
	chk_err_rdy: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("stray error");
	chk_pads_reset: assert property (!$past(nrst) |-> pad.oeN == 8'hFF)
		else $error("pads not idle");
	chk_alt_push: assert property (
		(ce && $stable(alt) && alt.en == 8'hFF && alt.pushPull == 8'hFF) [*3]
		|-> pad.oeN == 8'h00 && pad.out == alt.out) else $error("alt drive");
	chk_alt_drain: assert property (
		(ce && $stable(alt) && alt.en == 8'hFF && alt.pushPull == 8'h00) [*3]
		|-> pad.oeN == alt.out && (pad.out & ~pad.oeN) == 8'h00) else $error("drain");
	chk_pin_follow: assert property ((ce && $stable(padIn)) [*5] |-> altIn == padIn)
		else $error("pin level");
	chk_irq_hold: assert property (
		ce && irqReq && !vectorFetch && !apbReq.psel |=> irqReq) else $error("lost request");
endmodule : gpx_port_props

bind gpx_port gpx_port_props chk_u (.clk, .nrst, .ce, .apbReq, .apbRsp, .padIn, .pad, .alt,
	.altIn, .vectorFetch, .irqReq);

// [tb/gpx_pins_model.sv]
`timescale 1ns/1ps
// Pins with pull-ups and an outside driver
module gpx_pins_model (
	input wire gpx_pkg::gpx_pad_s pad,
	input wire logic [7:0] extOn,
	input wire logic [7:0] extVal,
	output logic [7:0] padIn
);
	import gpx_pkg::*;
	assign padIn = ~pad.oeN & pad.out | pad.oeN & (extOn & extVal | ~extOn);
endmodule : gpx_pins_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
// Bench for the pin port
module tb_top;
	import gpx_pkg::*;
	logic clk = 0, nrst = 0, vectorFetch = 0, irqReq;
	logic ce = 1'b1;
	logic [7:0] extOn = 0, extVal = 0, padIn, altIn;
	gpx_apb_req_s req = '0;
	gpx_apb_rsp_s rsp;
	gpx_pad_s pad;
	gpx_alt_s alt = '0;
	int badCount = 0, checked = 0;
	gpx_port dut_u (.clk, .nrst, .ce, .apbReq(req), .apbRsp(rsp), .padIn, .pad, .alt,
		.altIn, .vectorFetch, .irqReq);
	gpx_pins_model pins_u (.pad, .extOn, .extVal, .padIn);
	// 25 ns clock
	initial forever #12.5 clk = ~clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			badCount++;
			$display("mismatch %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// APB transfer; d is write data or expected read data
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
		@(posedge clk);
		req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge clk);
		req.penable <= 1'b1;
		// Wait for ready; only the watchdog ends a hang
		do @(posedge clk); while (rsp.pready !== 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (!w) chk(rsp.prdata, d);
		chk(rsp.pslverr, er);
	endtask : apb
	task automatic pins(input logic [7:0] v);
		extVal <= v;
		repeat (4) @(posedge clk);
	endtask : pins
	task automatic t_regs;
		apb(0, GPX_OFS_DIR, 0, 0);
		apb(0, GPX_OFS_OPT, 0, 0);
		apb(0, GPX_OFS_SENS, 0, 0);
		apb(0, GPX_OFS_DATA, 8'hFF, 0);
		apb(0, 12'h014, 0, 1);
		apb(1, GPX_OFS_STAT, 1, 1);
		$display("regs done");
	endtask : t_regs
	task automatic t_out;
		apb(1, GPX_OFS_DATA, 8'hA5, 0);
		chk(pad.oeN, 8'hFF);
		apb(1, GPX_OFS_OPT, 8'h0F, 0);
		apb(1, GPX_OFS_DIR, 8'hFF, 0);
		extOn <= 8'h80;
		repeat (4) @(posedge clk);
		chk(pad.oeN, 8'hA0);
		chk(pad.out & ~pad.oeN, 8'h05);
		apb(0, GPX_OFS_DATA, 8'h25, 0);
		$display("out done");
	endtask : t_out
	task automatic t_irq;
		apb(1, GPX_OFS_DIR, 0, 0);
		apb(1, GPX_OFS_OPT, 8'h03, 0);
		apb(1, GPX_OFS_SENS, GPX_SENS_RISE, 0);
		extOn <= 8'h03;
		pins(8'h01);
		pins(8'h00);
		pins(8'h01);
		chk(irqReq, 0);
		pins(8'h02);
		pins(8'h03);
		chk(irqReq, 1);
		apb(0, GPX_OFS_STAT, 1, 0);
		vectorFetch <= 1'b1;
		@(posedge clk);
		vectorFetch <= 1'b0;
		@(posedge clk);
		chk(irqReq, 0);
		pins(8'h02);
		pins(8'h03);
		chk(irqReq, 1);
		apb(1, GPX_OFS_SENS, GPX_SENS_BOTH, 0);
		@(posedge clk);
		chk(irqReq, 0);
		// Both edges: a fall sets the request
		pins(8'h02);
		chk(irqReq, 1);
		apb(1, GPX_OFS_SENS, GPX_SENS_FALL, 0);
		// Falling only: a rise is ignored
		pins(8'h03);
		chk(irqReq, 0);
		pins(8'h02);
		chk(irqReq, 1);
		$display("irq done");
	endtask : t_irq
	task automatic t_alt;
		apb(1, GPX_OFS_OPT, 0, 0);
		alt <= '{8'hFF, 8'h3C, 8'hFF};
		repeat (2) @(posedge clk);
		chk(pad.oeN, 8'h00);
		apb(0, GPX_OFS_DATA, 8'h3C, 0);
		alt.pushPull <= 8'h00;
		repeat (4) @(posedge clk);
		chk(pad.oeN, 8'h3C);
		alt <= '0;
		// Let the pin level reach the peripheral side
		repeat (5) @(posedge clk);
		$display("alt done");
	endtask : t_alt
	// Clock enable low freezes the pin path
	task automatic t_hold;
		chk(altIn, 8'hFE);
		ce <= 1'b0;
		extVal <= 8'h03;
		repeat (4) @(posedge clk);
		chk(altIn, 8'hFE);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		chk(altIn, 8'hFF);
		$display("hold done");
	endtask : t_hold
	task automatic wrapUp;
		$display("checked %0d bad %0d", checked, badCount);
		if (badCount == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrapUp
	// Reset, then the tests
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_out();
		t_irq();
		t_alt();
		t_hold();
		wrapUp();
	end
	// Watchdog
	initial begin
		#100us;
		badCount++;
		wrapUp();
	end
endmodule : tb_top
